/* rtl/mgpw_map.svh */
// Register offsets, field positions, reset values and timing counts of the pulse unit.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
`ifndef MGPW_MAP_SVH
`define MGPW_MAP_SVH
`define MGPW_CLK_PERIOD_NS  40
`define MGPW_ADR_CTRL       8'h00
`define MGPW_ADR_CLKDIV     8'h04
`define MGPW_ADR_OUTEN      8'h08
`define MGPW_ADR_INVERT     8'h0C
`define MGPW_ADR_RIS        8'h10
`define MGPW_ADR_IEN        8'h14
`define MGPW_ADR_MIS        8'h18
`define MGPW_ADR_FLTLVL     8'h1C
`define MGPW_ADR_GEN_BASE   8'h40
`define MGPW_GEN_STRIDE     8'h20
`define MGPW_GOFF_CFG       3'h0
`define MGPW_GOFF_LOAD      3'h1
`define MGPW_GOFF_CMPA      3'h2
`define MGPW_GOFF_CMPB      3'h3
`define MGPW_GOFF_DBRISE    3'h4
`define MGPW_GOFF_DBFALL    3'h5
`define MGPW_GOFF_COUNT     3'h6
`define MGPW_CFG_EN         0
`define MGPW_CFG_UPDOWN     1
`define MGPW_CFG_DBEN       2
`define MGPW_CFG_IEZERO     3
`define MGPW_CFG_TRZERO     4
`define MGPW_CLKDIV_RST     3'h0
`define MGPW_CLKDIV_MAX     3'h6
`define MGPW_RIS_FAULT_LSB  4
`endif

/* rtl/mgpw_pkg.sv */
// Types shared by the pulse unit files.
// Assumes the map header supplies all numbers.
package mgpw_pkg;
   typedef enum logic [1:0] {
      MGPW_DIR_DOWN = 2'b01,
      MGPW_DIR_UP   = 2'b10
   } mgpw_dir_t;
endpackage : mgpw_pkg

/* rtl/mgpw_deadband.sv */
// Dead-band generator: builds a complementary pair from the first output and delays the rising edge of each.
// Assumes tick_i is the divided unit clock enable.
`timescale 1ns/1ps
module mgpw_deadband (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        tick_i,
   input  wire logic        a_i,
   input  wire logic [15:0] rise_i,
   input  wire logic [15:0] fall_i,
   output logic             a_o,
   output logic             b_o
);
   logic        prev_q;
   logic [15:0] cnt_q;
   logic        pend_q;
   wire         edge_w = tick_i && (a_i != prev_q);
   wire  [15:0] dly_w  = a_i ? rise_i : fall_i;
   wire         now_w  = dly_w == 16'h0000;
   // The edge tick itself is the first dead tick, so the count ends at one, not zero.
   wire         done_w = pend_q && tick_i && (cnt_q <= 16'h0001);
   // ========================================
   // Edge delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
         cnt_q  <= 16'h0000;
         pend_q <= 1'b0;
         a_o    <= 1'b0;
         b_o    <= 1'b0;
      end else if (edge_w) begin
         prev_q <= a_i;
         pend_q <= !now_w;
         cnt_q  <= dly_w;
         a_o    <= now_w && a_i;
         b_o    <= now_w && !a_i;
      end else if (done_w) begin
         pend_q <= 1'b0;
         a_o    <= prev_q;
         b_o    <= ~prev_q;
      end else if (pend_q && tick_i) begin
         cnt_q  <= cnt_q - 16'h0001;
      end
   end
endmodule : mgpw_deadband

/* rtl/mgpw_unit.sv */
// Multi-generator pulse-width unit with Wishbone register access.
// Assumes one 25 MHz clock, synchronous reset and fault pins from outside.
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "mgpw_map.svh"
module mgpw_unit
   import mgpw_pkg::*;
#(
   parameter int NGEN = 4
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic [3:0]  fault_input_pin_i,
   output logic      [7:0]  pulse_pin_o,
   output logic      [3:0]  gen_irq_o,
   output logic      [3:0]  gen_trig_o,
   output logic             irq_o
);
   // ========================================
   // Bus decode
   logic        ack_q;
   logic [2:0]  div_sel_q;
   logic [7:0]  outen_q;
   logic [7:0]  invert_q;
   logic [7:0]  fltlvl_q;
   logic [7:0]  ien_q;
   logic [7:0]  ris_q;
   logic [3:0]  fsync1_q;
   logic [3:0]  fsync2_q;
   logic [6:0]  divcnt_q;
   logic [4:0]  g_cfg_q   [4];
   logic [15:0] g_load_q  [4];
   logic [15:0] g_cmpa_q  [4];
   logic [15:0] g_cmpb_q  [4];
   logic [15:0] g_rise_q  [4];
   logic [15:0] g_fall_q  [4];
   logic [15:0] a_load_q  [4];
   logic [15:0] a_cmpa_q  [4];
   logic [15:0] a_cmpb_q  [4];
   logic [15:0] cnt_q     [4];
   mgpw_dir_t   dir_q     [4];
   logic [3:0]  oa_raw;
   logic [3:0]  ob_raw;
   logic [3:0]  db_a;
   logic [3:0]  db_b;
   logic [3:0]  zero_w;
   logic [7:0]  gen_pulse;
   logic [31:0] gen_rd    [4];
   wire         req_w   = cyc_i && stb_i && !ack_q;
   wire         wr_w    = req_w && we_i && sel_i[0];
   wire         is_gen  = adr_i >= `MGPW_ADR_GEN_BASE;
   wire  [7:0]  gofs    = adr_i - `MGPW_ADR_GEN_BASE;
   wire  [1:0]  gidx    = gofs[6:5];
   wire  [2:0]  greg    = gofs[4:2];
   wire         gvalid  = is_gen && (32'(gidx) < NGEN);
   wire  [3:0]  fault_w = fsync2_q;
   wire  [6:0]  div_mask = 7'((8'h01 << div_sel_q) - 8'h01);
   wire         tick_w  = (divcnt_q & div_mask) == 7'h00;
   wire  [7:0]  mis_w   = ris_q & ien_q;
   wire  [7:0]  ris_set;
   wire  [3:0]  fault_clr = (wr_w && adr_i == `MGPW_ADR_RIS) ? dat_i[7:4] : 4'h0;
   wire  [3:0]  gen_clr   = (wr_w && adr_i == `MGPW_ADR_RIS) ? dat_i[3:0] : 4'h0;
   assign irq_o  = |mis_w;
   assign ack_o  = ack_q;
   assign ris_set = {fault_w, gen_irq_o};
   // ========================================
   // Bus slave and control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_q <= req_w;
         if (req_w) begin
            case (adr_i)
               `MGPW_ADR_CLKDIV: dat_o <= {29'h0, div_sel_q};
               `MGPW_ADR_OUTEN:  dat_o <= {24'h0, outen_q};
               `MGPW_ADR_INVERT: dat_o <= {24'h0, invert_q};
               `MGPW_ADR_RIS:    dat_o <= {24'h0, ris_q};
               `MGPW_ADR_IEN:    dat_o <= {24'h0, ien_q};
               `MGPW_ADR_MIS:    dat_o <= {24'h0, mis_w};
               `MGPW_ADR_FLTLVL: dat_o <= {24'h0, fltlvl_q};
               default:          dat_o <= gvalid ? gen_rd[gidx] : 32'h0000_0000;
            endcase
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_sel_q <= `MGPW_CLKDIV_RST;
         outen_q   <= 8'h00;
         invert_q  <= 8'h00;
         fltlvl_q  <= 8'h00;
         ien_q     <= 8'h00;
      end else if (wr_w) begin
         if (adr_i == `MGPW_ADR_CLKDIV && dat_i[2:0] <= `MGPW_CLKDIV_MAX) begin
            div_sel_q <= dat_i[2:0];
         end
         if (adr_i == `MGPW_ADR_OUTEN) outen_q <= dat_i[7:0];
         if (adr_i == `MGPW_ADR_INVERT) invert_q <= dat_i[7:0];
         if (adr_i == `MGPW_ADR_FLTLVL) fltlvl_q <= dat_i[7:0];
         if (adr_i == `MGPW_ADR_IEN) ien_q <= dat_i[7:0];
      end
   end
   // Setting wins over a clear in the same cycle so no event is lost.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ris_q <= 8'h00;
      end else begin
         ris_q <= (ris_q & ~{fault_clr, gen_clr}) | ris_set;
      end
   end
   // ========================================
   // Clock divider and fault synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         divcnt_q <= 7'h00;
         fsync1_q <= 4'h0;
         fsync2_q <= 4'h0;
      end else begin
         divcnt_q <= divcnt_q + 7'h01;
         fsync1_q <= fault_input_pin_i;
         fsync2_q <= fsync1_q;
      end
   end
   // ========================================
   // Generators
   for (genvar g = 0; g < 4; g++) begin : gen_blk
      if (g < NGEN) begin : act
         wire at_zero = cnt_q[g] == 16'h0000;
         wire at_load = cnt_q[g] == a_load_q[g];
         wire sel_me  = wr_w && gvalid && gidx == 2'(g);
         assign zero_w[g] = at_zero;
         assign gen_rd[g] = (greg == `MGPW_GOFF_CFG)    ? {27'h0, g_cfg_q[g]} :
                            (greg == `MGPW_GOFF_LOAD)   ? {16'h0, g_load_q[g]} :
                            (greg == `MGPW_GOFF_CMPA)   ? {16'h0, g_cmpa_q[g]} :
                            (greg == `MGPW_GOFF_CMPB)   ? {16'h0, g_cmpb_q[g]} :
                            (greg == `MGPW_GOFF_DBRISE) ? {16'h0, g_rise_q[g]} :
                            (greg == `MGPW_GOFF_DBFALL) ? {16'h0, g_fall_q[g]} :
                            (greg == `MGPW_GOFF_COUNT)  ? {16'h0, cnt_q[g]} : 32'h0;
         assign oa_raw[g] = cnt_q[g] < a_cmpa_q[g];
         assign ob_raw[g] = cnt_q[g] < a_cmpb_q[g];
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               g_cfg_q[g]  <= 5'h00;
               g_load_q[g] <= 16'h0000;
               g_cmpa_q[g] <= 16'h0000;
               g_cmpb_q[g] <= 16'h0000;
               g_rise_q[g] <= 16'h0000;
               g_fall_q[g] <= 16'h0000;
            end else if (sel_me) begin
               case (greg)
                  `MGPW_GOFF_CFG:    g_cfg_q[g]  <= dat_i[4:0];
                  `MGPW_GOFF_LOAD:   g_load_q[g] <= dat_i[15:0];
                  `MGPW_GOFF_CMPA:   g_cmpa_q[g] <= dat_i[15:0];
                  `MGPW_GOFF_CMPB:   g_cmpb_q[g] <= dat_i[15:0];
                  `MGPW_GOFF_DBRISE: g_rise_q[g] <= dat_i[15:0];
                  `MGPW_GOFF_DBFALL: g_fall_q[g] <= dat_i[15:0];
                  default:           g_cfg_q[g]  <= g_cfg_q[g];
               endcase
            end
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               cnt_q[g]    <= 16'h0000;
               dir_q[g]    <= MGPW_DIR_DOWN;
               a_load_q[g] <= 16'h0000;
               a_cmpa_q[g] <= 16'h0000;
               a_cmpb_q[g] <= 16'h0000;
            end else if (tick_w && g_cfg_q[g][`MGPW_CFG_EN]) begin
               if (at_zero) begin
                  a_load_q[g] <= g_load_q[g];
                  a_cmpa_q[g] <= g_cmpa_q[g];
                  a_cmpb_q[g] <= g_cmpb_q[g];
               end
               case (dir_q[g])
                  MGPW_DIR_DOWN: begin
                     if (at_zero && g_cfg_q[g][`MGPW_CFG_UPDOWN]) begin
                        dir_q[g] <= MGPW_DIR_UP;
                        cnt_q[g] <= 16'h0001;
                     end else if (at_zero) begin
                        cnt_q[g] <= g_load_q[g];
                     end else begin
                        cnt_q[g] <= cnt_q[g] - 16'h0001;
                     end
                  end
                  MGPW_DIR_UP: begin
                     if (at_load || !g_cfg_q[g][`MGPW_CFG_UPDOWN]) begin
                        dir_q[g] <= MGPW_DIR_DOWN;
                        cnt_q[g] <= cnt_q[g] - 16'h0001;
                     end else begin
                        cnt_q[g] <= cnt_q[g] + 16'h0001;
                     end
                  end
                  default: dir_q[g] <= MGPW_DIR_DOWN;
               endcase
            end
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               gen_irq_o[g]  <= 1'b0;
               gen_trig_o[g] <= 1'b0;
            end else begin
               gen_irq_o[g]  <= tick_w && g_cfg_q[g][`MGPW_CFG_EN] && at_zero
                                && g_cfg_q[g][`MGPW_CFG_IEZERO];
               gen_trig_o[g] <= tick_w && g_cfg_q[g][`MGPW_CFG_EN] && at_zero
                                && g_cfg_q[g][`MGPW_CFG_TRZERO];
            end
         end
         mgpw_deadband u_db (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .tick_i (tick_w),
            .a_i    (oa_raw[g]),
            .rise_i (g_rise_q[g]),
            .fall_i (g_fall_q[g]),
            .a_o    (db_a[g]),
            .b_o    (db_b[g])
         );
         assign gen_pulse[2*g]   = g_cfg_q[g][`MGPW_CFG_DBEN] ? db_a[g] : oa_raw[g];
         assign gen_pulse[2*g+1] = g_cfg_q[g][`MGPW_CFG_DBEN] ? db_b[g] : ob_raw[g];
      end else begin : idle
         assign zero_w[g]       = 1'b1;
         assign gen_rd[g]       = 32'h0;
         assign oa_raw[g]       = 1'b0;
         assign ob_raw[g]       = 1'b0;
         assign db_a[g]         = 1'b0;
         assign db_b[g]         = 1'b0;
         assign gen_pulse[2*g]  = 1'b0;
         assign gen_pulse[2*g+1] = 1'b0;
         assign gen_irq_o[g]    = 1'b0;
         assign gen_trig_o[g]   = 1'b0;
      end
   end
   // ========================================
   // Output control: a faulted pair is forced to its programmed fault level on pins whose output enable is set.
   wire [7:0] fault_pair = {{2{fault_w[3]}}, {2{fault_w[2]}}, {2{fault_w[1]}}, {2{fault_w[0]}}};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_pin_o <= 8'h00;
      end else begin
         pulse_pin_o <= ((((gen_pulse ^ invert_q) & ~fault_pair) | (fltlvl_q & fault_pair))
                        & outen_q);
      end
   end
   // ========================================
   // Checks
   a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o) else $error("ack held two cycles");
   a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o) else $error("no ack after request");
   a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == |(ris_q & ien_q)) else $error("irq mismatch");
   a_fault_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      fault_w[0] |=> ris_q[`MGPW_RIS_FAULT_LSB]) else $error("fault not latched");
   a_fault_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (fault_clr[0] && !fault_w[0]) |=> !ris_q[`MGPW_RIS_FAULT_LSB]) else $error("clear lost");
   a_clear_only: assert property (@(posedge clk_i) disable iff (rst_i)
      (fault_clr == 4'h1 && ris_q[5]) |=> ris_q[5]) else $error("clear hit other");
   a_div_legal: assert property (@(posedge clk_i) disable iff (rst_i)
      div_sel_q <= `MGPW_CLKDIV_MAX) else $error("illegal divider");
   a_gen_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !g_cfg_q[0][`MGPW_CFG_EN] |=> $stable(cnt_q[0])) else $error("counter ran disabled");
   a_load_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (a_load_q[0] != $past(a_load_q[0])) |-> $past(zero_w[0])) else $error("late load");
   a_tick_rate: assert property (@(posedge clk_i) disable iff (rst_i)
      (div_sel_q == 3'h1 && $stable(div_sel_q) && tick_w) |=> !tick_w)
      else $error("tick too fast");
   c_fault_irq: cover property (@(posedge clk_i) ris_q[4] && irq_o);
   c_deadband: cover property (@(posedge clk_i) g_cfg_q[0][`MGPW_CFG_DBEN] && pulse_pin_o[1]);
   c_updown: cover property (@(posedge clk_i) dir_q[0] == MGPW_DIR_UP);
endmodule : mgpw_unit

/* verif/mgpw_load.sv */
// Power stage model that sits on the pulse pins and drives the fault pins.
// Assumes the bench commands faults and names the pairs that must never overlap.
`timescale 1ns/1ps
module mgpw_load (
   input  wire logic       clk_i,
   input  wire logic [7:0] pulse_pin_i,
   input  wire logic [3:0] fault_cmd_i,
   input  wire logic [3:0] pair_watch_i,
   output logic      [3:0] fault_pin_o,
   output int              overlap_o
);
   // ==========================================================
   // Fault sensing and shoot-through watch
   // A real bridge leg is destroyed if both switches conduct, so each clock with an overlap on a watched pair is counted once.
   initial overlap_o = 0;
   always @(posedge clk_i) begin
      fault_pin_o <= fault_cmd_i;
      for (int g = 0; g < 4; g++) begin
         if (pair_watch_i[g] && pulse_pin_i[2*g] && pulse_pin_i[2*g+1]) begin
            overlap_o <= overlap_o + 1;
         end
      end
   end
endmodule : mgpw_load

/* verif/tb.sv */
// Self-checking bench of the pulse unit with a register model and a load model.
// Assumes the map header and a 25 MHz clock; waveform figures are measured in clocks.
`timescale 1ns/1ps
`include "mgpw_map.svh"
module tb;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
   logic [7:0]  adr_i, pulse_pin_o, lvl;
   logic [3:0]  sel_i, fault_pin, fault_cmd, watch, gen_irq_o, gen_trig_o;
   logic [31:0] dat_i, dat_o, q, a;
   logic [31:0] mdl [logic [7:0]];
   int          errors, samples_checked, cycles, hi, per, ld, ca, cb, n, w;

   mgpw_unit #(.NGEN(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .fault_input_pin_i(fault_pin), .pulse_pin_o(pulse_pin_o), .gen_irq_o(gen_irq_o),
      .gen_trig_o(gen_trig_o), .irq_o(irq_o));
   mgpw_load u_load (.clk_i(clk_i), .pulse_pin_i(pulse_pin_o), .fault_cmd_i(fault_cmd),
      .pair_watch_i(watch), .fault_pin_o(fault_pin), .overlap_o(w));

   // ==========================================================
   // Clock, timeout and closing report
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test;
      $display("compares %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   // ==========================================================
   // Bus cycles, comparison and pulse measurement
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wb(input logic w_, input logic [7:0] ad, input logic [31:0] d);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w_; adr_i <= ad; dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      q = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   // Writes, then reads back against the model so every write is also a readback check.
   task automatic wrc(input logic [7:0] ad, input logic [31:0] d, input logic [31:0] m);
      wb(1'b1, ad, d);
      mdl[ad] = d & m;
      wb(1'b0, ad, 32'h0);
      chk(q, mdl[ad]);
   endtask : wrc
   function automatic logic [7:0] ga(input int g, input logic [2:0] off);
      return `MGPW_ADR_GEN_BASE + `MGPW_GEN_STRIDE * g[7:0] + {3'h0, off, 2'b00};
   endfunction : ga
   // Finds a rising edge, then times the high phase and the whole period in clocks.
   task automatic meas(input int p);
      int k;
      k = 0;
      while (pulse_pin_o[p] !== 1'b0 && k < 3000) begin @(posedge clk_i); k++; end
      while (pulse_pin_o[p] !== 1'b1 && k < 3000) begin @(posedge clk_i); k++; end
      hi = 0;
      while (pulse_pin_o[p] === 1'b1 && k < 3000) begin @(posedge clk_i); hi++; k++; end
      per = hi;
      while (pulse_pin_o[p] === 1'b0 && k < 3000) begin @(posedge clk_i); per++; k++; end
   endtask : meas

   // ==========================================================
   // Main sequence
   initial begin
      rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00;
      sel_i = 4'hF; dat_i = 32'h0; fault_cmd = 4'h0; watch = 4'h0;
      void'($urandom(32'hB9CD635A));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({24'h0, pulse_pin_o}, 32'h0);
      wb(1'b0, `MGPW_ADR_CLKDIV, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, `MGPW_ADR_RIS, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, 8'hF0, 32'h0);
      chk(q, 32'h0);
      $display("reset and map test done");
      for (int r = 0; r < 8; r++) begin
         wb(1'b1, `MGPW_ADR_CLKDIV, r);
         wb(1'b0, `MGPW_ADR_CLKDIV, 32'h0);
         chk(q, (r > 6) ? 32'h6 : r);
      end
      $display("divider test done");
      wrc(`MGPW_ADR_OUTEN, 32'hFF, 32'hFF);
      wrc(`MGPW_ADR_INVERT, 32'h88, 32'hFF);
      for (int g = 0; g < 4; g++) begin
         ld = 4 + $urandom % 8; ca = 1 + $urandom % ld; cb = 1 + $urandom % ld; n = $urandom % 3;
         wrc(ga(g, `MGPW_GOFF_LOAD), ld, 32'hFFFF);
         wrc(ga(g, `MGPW_GOFF_CMPA), ca, 32'hFFFF);
         wrc(ga(g, `MGPW_GOFF_CMPB), cb, 32'hFFFF);
         wrc(`MGPW_ADR_CLKDIV, n, 32'h7);
         wrc(ga(g, `MGPW_GOFF_CFG), 32'h1, 32'h1F);
         meas(2 * g);
         meas(2 * g);
         chk(per, (ld + 1) << n);
         chk(hi, ca << n);
         meas(2 * g + 1);
         meas(2 * g + 1);
         chk(hi, ((g % 2) ? (ld + 1 - cb) : cb) << n);
         wrc(ga(g, `MGPW_GOFF_CFG), 32'h0, 32'h1F);
      end
      wrc(`MGPW_ADR_CLKDIV, 32'h0, 32'h7);
      wrc(`MGPW_ADR_INVERT, 32'h0, 32'hFF);
      $display("generator test done");
      watch <= 4'h2;
      wrc(ga(1, `MGPW_GOFF_LOAD), 32'd11, 32'hFFFF);
      wrc(ga(1, `MGPW_GOFF_CMPA), 32'd6, 32'hFFFF);
      wrc(ga(1, `MGPW_GOFF_DBRISE), 32'd2, 32'hFFFF);
      wrc(ga(1, `MGPW_GOFF_DBFALL), 32'd3, 32'hFFFF);
      wrc(ga(1, `MGPW_GOFF_CFG), 32'h5, 32'h1F);
      meas(2);
      meas(2);
      chk(hi, 32'd4);
      chk(per, 32'd12);
      meas(3);
      meas(3);
      chk(hi, 32'd3);
      chk(w, 32'd0);
      wrc(ga(1, `MGPW_GOFF_CFG), 32'h0, 32'h1F);
      watch <= 4'h0;
      $display("dead band test done");
      wrc(ga(2, `MGPW_GOFF_CFG), 32'h19, 32'h1F);
      n = 0;
      while (gen_irq_o[2] !== 1'b1 && n < 200) begin @(posedge clk_i); n++; end
      chk(gen_trig_o[2], 1'b1);
      wrc(ga(2, `MGPW_GOFF_CFG), 32'h0, 32'h1F);
      wb(1'b0, `MGPW_ADR_RIS, 32'h0);
      chk(q[2], 1'b1);
      wb(1'b1, `MGPW_ADR_RIS, 32'h4);
      wb(1'b0, ga(2, `MGPW_GOFF_COUNT), 32'h0);
      a = q;
      repeat (20) @(posedge clk_i);
      wb(1'b0, ga(2, `MGPW_GOFF_COUNT), 32'h0);
      chk(q, a);
      $display("count gate test done");
      lvl = $urandom;
      wrc(`MGPW_ADR_FLTLVL, lvl, 32'hFF);
      wrc(`MGPW_ADR_IEN, 32'hF0, 32'hFF);
      fault_cmd <= 4'hF;
      n = 0;
      while (pulse_pin_o !== lvl && n < 30) begin @(posedge clk_i); n++; end
      chk(pulse_pin_o, lvl);
      wb(1'b0, `MGPW_ADR_MIS, 32'h0);
      chk(q, 32'hF0);
      fault_cmd <= 4'h0;
      repeat (6) @(posedge clk_i);
      // Clearing only after the fault inputs have dropped and settled, since a set wins over a clear in the same cycle.
      wb(1'b1, `MGPW_ADR_RIS, 32'h10);
      wb(1'b0, `MGPW_ADR_RIS, 32'h0);
      chk(q, 32'hE0);
      chk(irq_o, 1'b1);
      wb(1'b1, `MGPW_ADR_RIS, 32'h60);
      wb(1'b0, `MGPW_ADR_RIS, 32'h0);
      chk(q, 32'h80);
      wb(1'b1, `MGPW_ADR_RIS, 32'h80);
      wb(1'b0, `MGPW_ADR_RIS, 32'h0);
      chk(q, 32'h0);
      chk(irq_o, 1'b0);
      $display("fault test done");
      stop_test();
   end
endmodule : tb
